/* File: power_link_if.sv */
// Purpose: transaction-level sensor bus between host controller and sensor
// Assumes: both ends on the same clock; req is a one-cycle pulse
// Notes:   rsp_valid follows req by exactly one cycle
interface power_link_if;
  logic       req;
  logic [6:0] slave_addr;
  logic       addr_only;
  logic       rd;
  logic       bank;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic       rsp_valid;
  logic       rsp_ack;
  logic [7:0] rsp_data;

  modport dev_mp (
    input  req,
    input  slave_addr,
    input  addr_only,
    input  rd,
    input  bank,
    input  reg_addr,
    input  wdata,
    output rsp_valid,
    output rsp_ack,
    output rsp_data
  );

  modport host_mp (
    output req,
    output slave_addr,
    output addr_only,
    output rd,
    output bank,
    output reg_addr,
    output wdata,
    input  rsp_valid,
    input  rsp_ack,
    input  rsp_data
  );
endinterface

/* File: power_link_props.sv */
// Purpose: protocol, ordering and register checks on the sensor power link
// Assumes: one clock, synchronous active-low reset
// Notes:   shadows follow acknowledged writes only, so refused writes leave them alone
module power_link_props (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       req,
  input  wire logic [6:0] slave_addr,
  input  wire logic       addr_only,
  input  wire logic       rd,
  input  wire logic       bank,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] wdata,
  input  wire logic       rsp_valid,
  input  wire logic       rsp_ack,
  input  wire logic [7:0] rsp_data
);
  import power_seq_pkg::*;

  logic       susp_r;
  logic [7:0] op_r;
  logic [7:0] s12_r;
  logic [7:0] en_r;
  logic       wr_ok;
  logic       acc;

  ////////////////////////////////////////////////////////////////////////////
  // fields hold between requests, so they still describe the answered request
  assign wr_ok = rsp_valid && rsp_ack && !rd && !addr_only;
  assign acc   = req && !addr_only;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      susp_r <= 1'b0;
      op_r   <= OP_S1_STEP_RST;
      s12_r  <= S1_S2_STEP_RST;
      en_r   <= ENABLE_RST;
    end else begin
      if (wr_ok && bank == SUSPEND_BANK && reg_addr == SUSPEND_OFS && wdata[0]) begin
        susp_r <= 1'b1;
      end
      if (rsp_valid && rsp_ack && addr_only) begin
        susp_r <= 1'b0;
      end
      if (wr_ok && bank == STEP_BANK && reg_addr == OP_S1_STEP_OFS) begin
        op_r <= wdata;
      end
      if (wr_ok && bank == STEP_BANK && reg_addr == S1_S2_STEP_OFS) begin
        s12_r <= wdata;
      end
      if (wr_ok && bank == STEP_BANK && reg_addr == ENABLE_OFS) begin
        en_r <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  resp_next_a: assert property (req |=> rsp_valid)
    else $error("no response one cycle after request");
  resp_caused_a: assert property (rsp_valid |-> $past(req))
    else $error("response without request");
  suspend_order_a: assert property (
    acc && !rd && bank == SUSPEND_BANK && reg_addr == SUSPEND_OFS && wdata[0]
    |-> en_r == 8'h00) else $error("suspend issued while enabled");
  resume_order_a: assert property (
    !(acc && susp_r && !rd && bank == STEP_BANK && reg_addr == ENABLE_OFS))
    else $error("enable written before wake");
  wake_ack_a: assert property (
    req && addr_only && !rd && susp_r && slave_addr == SLAVE_ADDR_RST
    |=> rsp_ack) else $error("wake not acknowledged");
  susp_ignore_a: assert property (acc && susp_r |=> !rsp_ack)
    else $error("access acknowledged in suspend");
  reserved_zero_a: assert property (
    acc && !rd && ((bank == SUSPEND_BANK && reg_addr == SUSPEND_OFS) ||
    (bank == STEP_BANK && reg_addr == ENABLE_OFS)) |-> wdata[7:1] == 7'h00)
    else $error("reserved bits written nonzero");
  op_step_rd_a: assert property (
    acc && rd && bank == STEP_BANK && reg_addr == OP_S1_STEP_OFS ##1 rsp_ack
    |-> rsp_data == op_r) else $error("operate step read mismatch");
  s12_step_rd_a: assert property (
    acc && rd && bank == STEP_BANK && reg_addr == S1_S2_STEP_OFS ##1 rsp_ack
    |-> rsp_data == s12_r) else $error("standby step read mismatch");
  enable_rd_a: assert property (
    acc && rd && bank == STEP_BANK && reg_addr == ENABLE_OFS ##1 rsp_ack
    |-> rsp_data == en_r) else $error("enable read mismatch");
endmodule

/* File: power_seq_pkg.sv */
// Purpose: shared constants and types for the sensor power-state control link
// Assumes: one 20 MHz clock on both ends
// Notes:   register offsets are 8-bit sensor addresses, bank chosen by one bit
package power_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sensor register map
  localparam logic [7:0] SUSPEND_OFS       = 8'h03;
  localparam logic [7:0] STEP_HI_A_OFS     = 8'h6b;
  localparam logic [7:0] OP_S1_STEP_OFS    = 8'h6c;
  localparam logic [7:0] STEP_HI_B_OFS     = 8'h6d;
  localparam logic [7:0] S1_S2_STEP_OFS    = 8'h6e;
  localparam logic [7:0] ENABLE_OFS        = 8'h72;
  localparam logic       SUSPEND_BANK      = 1'b0;
  localparam logic       STEP_BANK         = 1'b1;

  localparam logic [7:0] SUSPEND_RST       = 8'h01;
  localparam logic [7:0] STEP_HI_A_RST     = 8'hb0;
  localparam logic [7:0] OP_S1_STEP_RST    = 8'h04;
  localparam logic [7:0] STEP_HI_B_RST     = 8'h60;
  localparam logic [7:0] S1_S2_STEP_RST    = 8'h09;
  localparam logic [7:0] ENABLE_RST        = 8'h00;
  localparam int         CTRL_BIT_POS      = 0;
  localparam logic [7:0] CTRL_BIT_MASK     = 8'h01;

  localparam logic [6:0] SLAVE_ADDR_RST    = 7'h73;

  ////////////////////////////////////////////////////////////////////////////
  // timing: one step of the power timers
  localparam int         CLK_KHZ           = 20000;
  localparam int         STEP_TIME_US      = 1000;
  localparam int         STEP_CYCLES       = (STEP_TIME_US * CLK_KHZ) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // host command port
  localparam logic [1:0] HOST_CMD_OFS      = 2'h0;
  localparam logic [1:0] HOST_WDATA_OFS    = 2'h1;
  localparam logic [1:0] HOST_STATUS_OFS   = 2'h2;
  localparam int         CMD_KIND_POS      = 0;
  localparam int         CMD_BANK_POS      = 3;
  localparam int         CMD_REG_POS       = 8;
  localparam int         STAT_BUSY_POS     = 0;
  localparam int         STAT_NACK_POS     = 1;
  localparam int         STAT_DATA_POS     = 8;

  typedef enum logic [2:0] {
    CMD_WRITE,
    CMD_READ,
    CMD_WAKE,
    CMD_SUSPEND,
    CMD_RESUME
  } cmd_kind_type;

  typedef enum logic [2:0] {
    PWR_DISABLED,
    PWR_OPERATE,
    PWR_STANDBY1,
    PWR_STANDBY2,
    PWR_SUSPEND
  } pwr_state_type;

endpackage

/* File: sensor_power_host.sv */
// Purpose: host end: runs single accesses and the suspend/resume sequences
// Assumes: software port with read data one cycle after the read strobe
// Notes:   a command written while busy is dropped
module sensor_power_host #(
  parameter logic [6:0] SLAVE_ADDR = power_seq_pkg::SLAVE_ADDR_RST
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  power_link_if.host_mp    lnk,
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata
);
  import power_seq_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE,
    H_REQ,
    H_WAIT
  } host_state_type;

  typedef struct packed {
    host_state_type st;
    cmd_kind_type   kind;
    logic           bank;
    logic [7:0]     reg_addr;
    logic [7:0]     wdata;
    logic           step;
    logic           nack;
    logic [7:0]     rdata;
    logic           req;
    logic           addr_only;
    logic           rd;
    logic           lbank;
    logic [7:0]     laddr;
    logic [7:0]     lwdata;
    logic [15:0]    rd_out;
  } host_reg_type;

  host_reg_type r;
  host_reg_type r_nxt;
  logic         busy;
  logic         two_step;
  logic [15:0]  status;

  always_comb begin
    r_nxt     = r;
    r_nxt.req = 1'b0;
    busy      = (r.st != H_IDLE);
    two_step  = (r.kind == CMD_SUSPEND) || (r.kind == CMD_RESUME);
    status    = 16'h0000;
    status[STAT_BUSY_POS] = busy;
    status[STAT_NACK_POS] = r.nack;
    status[STAT_DATA_POS +: 8] = r.rdata;

    r_nxt.rd_out = 16'h0000;
    if (i_rd && (i_addr == HOST_STATUS_OFS)) begin
      r_nxt.rd_out = status;
    end else if (i_rd && (i_addr == HOST_WDATA_OFS)) begin
      r_nxt.rd_out = {8'h00, r.wdata};
    end
    if (i_wr && (i_addr == HOST_WDATA_OFS)) begin
      r_nxt.wdata = i_wdata[7:0];
    end

    unique case (r.st)
      H_IDLE: begin
        if (i_wr && (i_addr == HOST_CMD_OFS)
            && (i_wdata[CMD_KIND_POS +: 3] <= 3'(CMD_RESUME))) begin
          r_nxt.kind     = cmd_kind_type'(i_wdata[CMD_KIND_POS +: 3]);
          r_nxt.bank     = i_wdata[CMD_BANK_POS];
          r_nxt.reg_addr = i_wdata[CMD_REG_POS +: 8];
          r_nxt.step     = 1'b0;
          r_nxt.st       = H_REQ;
        end
      end
      H_REQ: begin
        r_nxt.req       = 1'b1;
        r_nxt.addr_only = 1'b0;
        r_nxt.rd        = 1'b0;
        r_nxt.lbank     = r.bank;
        r_nxt.laddr     = r.reg_addr;
        r_nxt.lwdata    = r.wdata;
        unique case (r.kind)
          CMD_READ: r_nxt.rd = 1'b1;
          CMD_WAKE: r_nxt.addr_only = 1'b1;
          CMD_SUSPEND: begin
            // disable first, then the suspend command
            r_nxt.lbank  = r.step ? SUSPEND_BANK : STEP_BANK;
            r_nxt.laddr  = r.step ? SUSPEND_OFS : ENABLE_OFS;
            r_nxt.lwdata = r.step ? CTRL_BIT_MASK : 8'h00;
          end
          CMD_RESUME: begin
            // wake first, then enable again
            r_nxt.addr_only = !r.step;
            r_nxt.lbank     = STEP_BANK;
            r_nxt.laddr     = ENABLE_OFS;
            r_nxt.lwdata    = CTRL_BIT_MASK;
          end
          CMD_WRITE: begin
            // reserved bits of the control registers always go out as zero
            if (hit_ctrl(r.bank, r.reg_addr)) begin
              r_nxt.lwdata = r.wdata & CTRL_BIT_MASK;
            end
          end
        endcase
        r_nxt.st = H_WAIT;
      end
      H_WAIT: begin
        if (lnk.rsp_valid) begin
          r_nxt.nack = !lnk.rsp_ack;
          if (r.kind == CMD_READ) begin
            r_nxt.rdata = lnk.rsp_data;
          end
          if (two_step && !r.step && lnk.rsp_ack) begin
            r_nxt.step = 1'b1;
            r_nxt.st   = H_REQ;
          end else begin
            r_nxt.st = H_IDLE;
          end
        end
      end
      default: r_nxt.st = H_IDLE;
    endcase
  end

  function automatic logic hit_ctrl(input logic b, input logic [7:0] a);
    hit_ctrl = ((b == SUSPEND_BANK) && (a == SUSPEND_OFS))
               || ((b == STEP_BANK) && (a == ENABLE_OFS));
  endfunction

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      r      <= '0;
      r.st   <= H_IDLE;
      r.kind <= CMD_WRITE;
    end else begin
      r <= r_nxt;
    end
  end

  assign lnk.req        = r.req;
  assign lnk.slave_addr = SLAVE_ADDR;
  assign lnk.addr_only  = r.addr_only;
  assign lnk.rd         = r.rd;
  assign lnk.bank       = r.lbank;
  assign lnk.reg_addr   = r.laddr;
  assign lnk.wdata      = r.lwdata;
  assign o_rdata        = r.rd_out;

endmodule

/* File: sensor_power_state_control.sv */
// Purpose: sensor end: power registers, power-state machine, wake and suspend
// Assumes: i_motion comes from the analog front end, asynchronous to i_ref_clk
// Notes:   step timers count in units of STEP_CYCLES clocks
module sensor_power_state_control #(
  parameter int         STEP_CYC   = power_seq_pkg::STEP_CYCLES,
  parameter logic [6:0] SLAVE_ADDR = power_seq_pkg::SLAVE_ADDR_RST
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_b,
  power_link_if.dev_mp                      lnk,
  input  wire logic                         i_motion,
  output logic                              o_detect,
  output power_seq_pkg::pwr_state_type      o_power_state,
  output logic                              o_sensing_on
);
  import power_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pwr_state_type st;
    logic [7:0]    step_hi_a;
    logic [7:0]    op_s1_step;
    logic [7:0]    step_hi_b;
    logic [7:0]    s1_s2_step;
    logic [7:0]    enable;
    logic [7:0]    suspend_cmd;
    logic [15:0]   div_cnt;
    logic          step_tick;
    logic [7:0]    step_cnt;
    logic [2:0]    motion_sync;
    logic          motion_lvl;
    logic          rsp_valid;
    logic          rsp_ack;
    logic [7:0]    rsp_data;
    logic          detect;
    logic          sensing_on;
  } dev_state_type;

  dev_state_type r;
  dev_state_type r_nxt;

  function automatic logic hit(input logic b, input logic [7:0] a,
                               input logic bb, input logic [7:0] aa);
    hit = (b == bb) && (a == aa);
  endfunction

  function automatic logic [7:0] reg_read(input dev_state_type s, input logic b,
                                          input logic [7:0] a);
    reg_read = 8'h00;
    if (hit(b, a, SUSPEND_BANK, SUSPEND_OFS))   reg_read = s.suspend_cmd;
    if (hit(b, a, STEP_BANK, STEP_HI_A_OFS))    reg_read = s.step_hi_a;
    if (hit(b, a, STEP_BANK, OP_S1_STEP_OFS))   reg_read = s.op_s1_step;
    if (hit(b, a, STEP_BANK, STEP_HI_B_OFS))    reg_read = s.step_hi_b;
    if (hit(b, a, STEP_BANK, S1_S2_STEP_OFS))   reg_read = s.s1_s2_step;
    if (hit(b, a, STEP_BANK, ENABLE_OFS))       reg_read = s.enable;
  endfunction

  logic for_me;
  logic wake_req;
  logic do_wr;
  logic do_susp;
  logic stable_motion;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_nxt = r;
    r_nxt.rsp_valid = 1'b0;
    r_nxt.rsp_ack   = 1'b0;
    r_nxt.detect    = 1'b0;
    r_nxt.step_tick = 1'b0;

    // front-end level: three stages, accepted once the last two agree
    r_nxt.motion_sync = {r.motion_sync[1:0], i_motion};
    if (r.motion_sync[2] == r.motion_sync[1]) begin
      r_nxt.motion_lvl = r.motion_sync[2];
    end
    stable_motion = r.motion_lvl;

    // step divider
    if (r.div_cnt >= 16'(STEP_CYC - 1)) begin
      r_nxt.div_cnt   = 16'h0000;
      r_nxt.step_tick = 1'b1;
    end else begin
      r_nxt.div_cnt = r.div_cnt + 16'h0001;
    end

    // bus side
    for_me   = lnk.req && (lnk.slave_addr == SLAVE_ADDR);
    wake_req = for_me && lnk.addr_only && !lnk.rd;
    do_wr    = 1'b0;
    do_susp  = 1'b0;
    if (r.st == PWR_SUSPEND) begin
      // only the address-only write is acknowledged while suspended; other requests get a nack
      if (wake_req) begin
        r_nxt.rsp_valid = 1'b1;
        r_nxt.rsp_ack   = 1'b1;
        r_nxt.st        = PWR_DISABLED;
        r_nxt.step_cnt  = 8'h00;
      end else if (lnk.req) begin
        r_nxt.rsp_valid = 1'b1;
      end
    end else if (lnk.req) begin
      r_nxt.rsp_valid = 1'b1;
      r_nxt.rsp_ack   = for_me;
      do_wr           = for_me && !lnk.addr_only && !lnk.rd;
      if (for_me && lnk.rd && !lnk.addr_only) begin
        r_nxt.rsp_data = reg_read(r, lnk.bank, lnk.reg_addr);
      end
    end

    if (do_wr) begin
      if (hit(lnk.bank, lnk.reg_addr, STEP_BANK, STEP_HI_A_OFS)) begin
        r_nxt.step_hi_a = lnk.wdata;
      end
      if (hit(lnk.bank, lnk.reg_addr, STEP_BANK, OP_S1_STEP_OFS)) begin
        r_nxt.op_s1_step = lnk.wdata;
      end
      if (hit(lnk.bank, lnk.reg_addr, STEP_BANK, STEP_HI_B_OFS)) begin
        r_nxt.step_hi_b = lnk.wdata;
      end
      if (hit(lnk.bank, lnk.reg_addr, STEP_BANK, S1_S2_STEP_OFS)) begin
        r_nxt.s1_s2_step = lnk.wdata;
      end
      // reserved bits are kept as written; only bit 0 acts
      if (hit(lnk.bank, lnk.reg_addr, STEP_BANK, ENABLE_OFS)) begin
        r_nxt.enable = lnk.wdata;
      end
      if (hit(lnk.bank, lnk.reg_addr, SUSPEND_BANK, SUSPEND_OFS)) begin
        r_nxt.suspend_cmd = lnk.wdata;
        do_susp = lnk.wdata[CTRL_BIT_POS];
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // power states; suspend beats everything else
    if (do_susp) begin
      r_nxt.st       = PWR_SUSPEND;
      r_nxt.step_cnt = 8'h00;
    end else if (r.st != PWR_SUSPEND) begin
      if (!r_nxt.enable[CTRL_BIT_POS]) begin
        r_nxt.st       = PWR_DISABLED;
        r_nxt.step_cnt = 8'h00;
      end else begin
        unique case (r.st)
          PWR_DISABLED: begin
            r_nxt.st       = PWR_OPERATE;
            r_nxt.step_cnt = 8'h00;
          end
          PWR_OPERATE: begin
            if (stable_motion) begin
              r_nxt.step_cnt = 8'h00;
            end else if (r.step_tick) begin
              if (r.step_cnt >= r.op_s1_step) begin
                r_nxt.st       = PWR_STANDBY1;
                r_nxt.step_cnt = 8'h00;
              end else begin
                r_nxt.step_cnt = r.step_cnt + 8'h01;
              end
            end
          end
          PWR_STANDBY1: begin
            if (stable_motion) begin
              r_nxt.st       = PWR_OPERATE;
              r_nxt.step_cnt = 8'h00;
            end else if (r.step_tick) begin
              if (r.step_cnt >= r.s1_s2_step) begin
                r_nxt.st       = PWR_STANDBY2;
                r_nxt.step_cnt = 8'h00;
              end else begin
                r_nxt.step_cnt = r.step_cnt + 8'h01;
              end
            end
          end
          PWR_STANDBY2: begin
            if (stable_motion) begin
              r_nxt.st       = PWR_OPERATE;
              r_nxt.step_cnt = 8'h00;
            end
          end
          PWR_SUSPEND: begin
            r_nxt.st = PWR_SUSPEND;
          end
        endcase
      end
    end

    // registered beside the state so the flag never lags the state output
    r_nxt.sensing_on = (r_nxt.st == PWR_OPERATE) || (r_nxt.st == PWR_STANDBY1)
                       || (r_nxt.st == PWR_STANDBY2);

    // detection only while sensing; the default above keeps it to one pulse
    if (r_nxt.motion_lvl && !r.motion_lvl && r.enable[CTRL_BIT_POS]
        && (r.st != PWR_SUSPEND) && (r.st != PWR_DISABLED)) begin
      r_nxt.detect = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      r             <= '0;
      r.st          <= PWR_DISABLED;
      r.step_hi_a   <= STEP_HI_A_RST;
      r.op_s1_step  <= OP_S1_STEP_RST;
      r.step_hi_b   <= STEP_HI_B_RST;
      r.s1_s2_step  <= S1_S2_STEP_RST;
      r.enable      <= ENABLE_RST;
      r.suspend_cmd <= SUSPEND_RST;
    end else begin
      r <= r_nxt;
    end
  end

  assign lnk.rsp_valid = r.rsp_valid;
  assign lnk.rsp_ack   = r.rsp_ack;
  assign lnk.rsp_data  = r.rsp_data;
  assign o_detect      = r.detect;
  assign o_power_state = r.st;
  assign o_sensing_on  = r.sensing_on;

endmodule

/* File: test_sensor_power_state_control.sv */
// Purpose: host and sensor ends joined, driven through the software port
// Assumes: 20 MHz clock, step timer shortened to 4 clocks
// Notes:   status reads mask to data, nack and busy
module test_sensor_power_state_control;
  timeunit 1ns;
  timeprecision 1ns;
  import power_seq_pkg::*;

  localparam int STEP = 4;
  logic          i_ref_clk;
  logic          i_rst_b;
  logic          i_motion;
  logic          i_wr;
  logic          i_rd;
  logic [1:0]    i_addr;
  logic [15:0]   i_wdata;
  logic [15:0]   o_rdata;
  logic          o_detect;
  logic          o_sensing_on;
  pwr_state_type o_power_state;
  int            fail_count = 0;
  int            n_compared = 0;

  power_link_if lnk ();
  sensor_power_state_control #(.STEP_CYC(STEP)) u_sensor_power_state_control (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .lnk(lnk), .i_motion(i_motion),
    .o_detect(o_detect), .o_power_state(o_power_state), .o_sensing_on(o_sensing_on));
  sensor_power_host u_sensor_power_host (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .lnk(lnk), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  power_link_props u_power_link_props (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .req(lnk.req), .slave_addr(lnk.slave_addr),
    .addr_only(lnk.addr_only), .rd(lnk.rd), .bank(lnk.bank), .reg_addr(lnk.reg_addr),
    .wdata(lnk.wdata), .rsp_valid(lnk.rsp_valid), .rsp_ack(lnk.rsp_ack),
    .rsp_data(lnk.rsp_data));

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // polls busy with a bound; a hung link ends the run instead of stalling it
  task automatic cmd(input cmd_kind_type k, input logic b, input logic [7:0] r,
                     input logic [7:0] wd, output logic [15:0] st);
    sw_wr(HOST_WDATA_OFS, {8'h00, wd});
    sw_wr(HOST_CMD_OFS, {r, 4'h0, b, k});
    for (int i = 0; i < 60; i++) begin
      sw_rd(HOST_STATUS_OFS, st);
      st = st & 16'hff03;
      if (st[STAT_BUSY_POS] === 1'b0) return;
    end
    check("busy", 16'h0000, 16'h0001);
    finish_test();
  endtask

  task automatic wait_state(input pwr_state_type s, input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(posedge i_ref_clk);
      #1;
      if (o_power_state === s) return;
    end
    check("state", {13'h0, s}, {13'h0, o_power_state});
    finish_test();
  endtask

  task automatic watch_detect(output logic seen);
    seen = 1'b0;
    repeat (8) begin
      @(posedge i_ref_clk);
      #1;
      if (o_detect === 1'b1) seen = 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] st;
    logic [7:0]  ofs [6];
    logic [7:0]  rv  [6];
    ofs = '{SUSPEND_OFS, STEP_HI_A_OFS, OP_S1_STEP_OFS, STEP_HI_B_OFS, S1_S2_STEP_OFS,
            ENABLE_OFS};
    rv  = '{SUSPEND_RST, STEP_HI_A_RST, OP_S1_STEP_RST, STEP_HI_B_RST, S1_S2_STEP_RST,
            ENABLE_RST};
    check("state", {13'h0, PWR_DISABLED}, {13'h0, o_power_state});
    for (int i = 0; i < 6; i++) begin
      cmd(CMD_READ, (i == 0) ? SUSPEND_BANK : STEP_BANK, ofs[i], 8'h00, st);
      check("reset value", {rv[i], 8'h00}, st);
    end
    cmd(CMD_READ, STEP_BANK, 8'h70, 8'h00, st);
    check("unmapped", 16'h0000, st);
    $display("test reset done");
  endtask

  task automatic t_steps();
    logic [15:0] st;
    logic        seen;
    int          n;
    cmd(CMD_WRITE, STEP_BANK, OP_S1_STEP_OFS, 8'h01, st);
    cmd(CMD_WRITE, STEP_BANK, S1_S2_STEP_OFS, 8'h02, st);
    sw_rd(HOST_WDATA_OFS, st);
    check("wdata reg", 16'h0002, st);
    cmd(CMD_READ, STEP_BANK, OP_S1_STEP_OFS, 8'h00, st);
    check("op step", 16'h0100, st);
    cmd(CMD_READ, STEP_BANK, S1_S2_STEP_OFS, 8'h00, st);
    check("s1 step", 16'h0200, st);
    cmd(CMD_WRITE, STEP_BANK, ENABLE_OFS, 8'h01, st);
    check("sensing", 16'h1, {15'h0, o_sensing_on});
    wait_state(PWR_STANDBY1, 40, n);
    wait_state(PWR_STANDBY2, 40, n);
    check("s1 dwell ok", 16'h1, {15'h0, n > 2 * STEP && n <= 4 * STEP});
    @(posedge i_ref_clk);
    i_motion <= 1'b1;
    watch_detect(seen);
    check("detect", 16'h1, {15'h0, seen});
    check("state", {13'h0, PWR_OPERATE}, {13'h0, o_power_state});
    $display("test steps done");
  endtask

  // motion is raised while suspended and kept high, so resume lands in operate
  task automatic t_suspend();
    logic [15:0] st;
    logic        seen;
    @(posedge i_ref_clk);
    i_motion <= 1'b0;
    cmd(CMD_SUSPEND, SUSPEND_BANK, SUSPEND_OFS, 8'h00, st);
    check("susp status", 16'h0000, st & 16'h0003);
    check("state", {13'h0, PWR_SUSPEND}, {13'h0, o_power_state});
    @(posedge i_ref_clk);
    i_motion <= 1'b1;
    watch_detect(seen);
    check("detect", 16'h0, {15'h0, seen | o_sensing_on});
    cmd(CMD_READ, STEP_BANK, OP_S1_STEP_OFS, 8'h00, st);
    check("nack", 16'h0002, st & 16'h0003);
    cmd(CMD_RESUME, STEP_BANK, ENABLE_OFS, 8'h00, st);
    check("state", {13'h0, PWR_OPERATE}, {13'h0, o_power_state});
    cmd(CMD_READ, STEP_BANK, ENABLE_OFS, 8'h00, st);
    check("enable", 16'h0100, st);
    $display("test suspend done");
  endtask

  task automatic t_disable();
    logic [15:0] st;
    logic        seen;
    cmd(CMD_WRITE, STEP_BANK, ENABLE_OFS, 8'hfe, st);
    cmd(CMD_READ, STEP_BANK, ENABLE_OFS, 8'h00, st);
    check("masked", 16'h0000, st);
    check("state", {13'h0, PWR_DISABLED}, {13'h0, o_power_state});
    // a wake while awake is answered but changes nothing
    cmd(CMD_WAKE, STEP_BANK, 8'h00, 8'h00, st);
    check("wake awake", 16'h0000, st & 16'h0003);
    check("state", {13'h0, PWR_DISABLED}, {13'h0, o_power_state});
    @(posedge i_ref_clk);
    i_motion <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_motion <= 1'b1;
    watch_detect(seen);
    check("detect", 16'h0, {15'h0, seen | o_sensing_on});
    $display("test disable done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_b  = 1'b0;
    i_motion = 1'b0;
    i_wr     = 1'b0;
    i_rd     = 1'b0;
    i_addr   = 2'h0;
    i_wdata  = 16'h0000;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_steps();
    t_suspend();
    t_disable();
    finish_test();
  end
endmodule
